// ==== rtl/bpm_pkg.sv ====
// Constants and types for the bus port pin function multiplexer
// Operation
// - With an 8-bit bus the lower port stays general I/O.
// - In expanded modes with a 16-bit bus the lower port carries data bits 7..0 both ways.
// - Expanded modes: clock pin direction resets to 1; clearing it makes an input.
// - Single-chip modes: clock pin direction resets to 0; setting it drives clock.
// - Expanded modes drive address, read, upper and lower write strobes on bits 6..3.
// - Single-chip modes: bits 3..0 are I/O plus interrupts, bits 6..4 plain I/O.
// - Wait and request-out enables reset to 0; bit 2 is then I/O plus interrupt 2.
// - Expanded modes: wait enable alone makes bit 2 wait input; request-out enable alone drives request.
// - Control port is 8 bits; interrupts 0..3 always follow their pins.
// - Each port has direction, data and pin-state registers.
package bpm_pkg;
    localparam int BPM_PORT_W = 8;
    localparam int BPM_SYNC_CYCLES = 3;
    // Control port bit positions
    localparam int BPM_CLK_BIT = 7;
    localparam int BPM_ADDR_BIT = 6;
    localparam int BPM_RD_BIT = 5;
    localparam int BPM_UWR_BIT = 4;
    localparam int BPM_LOW_WR_BIT = 3;
    localparam int BPM_WAIT_BIT = 2;
    localparam int BPM_GRANT_BIT = 1;
    localparam int BPM_REQ_IN_BIT = 0;
    // Values after reset
    localparam logic [7:0] BPM_DIR_RST = 8'h00;
    localparam logic [7:0] BPM_DATA_RST = 8'h00;
    localparam logic BPM_ENABLE_RST = 1'h0;
    localparam logic BPM_CLKDIR_EXP_RST = 1'h1;
    localparam logic BPM_CLKDIR_SC_RST = 1'h0;
    localparam logic BPM_IDLE_LEVEL = 1'h1;
    localparam logic [1:0] BPM_CAPTURE_WAIT = 2'h3;

    typedef enum logic [0:0] {
        BPM_ST_CAPTURE = 1'h0,
        BPM_ST_RUN = 1'h1
    } bpm_state_t;

    // Modes 1, 2, 4, 5, 6 use the external bus; 3, 7 and the unused 0 are single-chip
    function automatic logic bpm_is_expanded(input logic [2:0] mode);
        case (mode)
            3'h1, 3'h2, 3'h4, 3'h5, 3'h6: bpm_is_expanded = 1'b1;
            default: bpm_is_expanded = 1'b0;
        endcase
    endfunction : bpm_is_expanded
endpackage : bpm_pkg

// ==== rtl/bpm_pin_mux.sv ====
// Pin function multiplexer for the data and control ports
module bpm_pin_mux
    import bpm_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic resetn,
    // Mode and bus width straps
    input wire logic [2:0] mode_pins,
    input wire logic bus16_pin,
    // Port register writes
    input wire logic [7:0] wr_value,
    input wire logic upper_dir_we,
    input wire logic lower_dir_we,
    input wire logic ctrl_dir_we,
    input wire logic upper_data_we,
    input wire logic lower_data_we,
    input wire logic ctrl_data_we,
    // Pin function enables
    input wire logic enables_we,
    input wire logic wait_pin_enable_in,
    input wire logic bus_request_out_enable_in,
    input wire logic bus_release_enable_in,
    // Bus controller side
    input wire logic [15:0] bus_wdata,
    input wire logic bus_drive,
    input wire logic address_strobe,
    input wire logic read_strobe,
    input wire logic upper_write_strobe,
    input wire logic lower_write_strobe,
    input wire logic bus_request_output,
    input wire logic bus_grant_output,
    // Core side results
    output logic [15:0] bus_rdata,
    output logic wait_pin_level,
    output logic bus_request_input,
    output logic [3:0] external_interrupt,
    output logic expanded_mode,
    output logic [7:0] upper_pin_state,
    output logic [7:0] lower_pin_state,
    output logic [7:0] ctrl_pin_state,
    output logic [7:0] ctrl_dir,
    output logic [2:0] pin_enables,
    // Pins
    input wire logic [7:0] upper_pin_in,
    output logic [7:0] upper_pin_out,
    output logic [7:0] upper_pin_oe,
    input wire logic [7:0] lower_pin_in,
    output logic [7:0] lower_pin_out,
    output logic [7:0] lower_pin_oe,
    input wire logic [7:0] ctrl_pin_in,
    output logic [7:0] ctrl_pin_out,
    output logic [7:0] ctrl_pin_oe
);
    localparam int W = BPM_PORT_W;
    localparam int SW = 3 * W + 4;

    // Three-stage synchronisers; only stage two and three are compared
    logic [SW-1:0] s1_r, s2_r, s3_r;
    logic [SW-1:0] filt_r, filt_nxt;
    bpm_state_t state_r, state_nxt;
    logic [1:0] wait_r, wait_nxt;
    logic [2:0] mode_r, mode_nxt;
    logic bus16_r, bus16_nxt, exp_r, exp_nxt;
    logic [W-1:0] udir_r, udir_nxt, ldir_r, ldir_nxt, cdir_r, cdir_nxt;
    logic [W-1:0] udat_r, udat_nxt, ldat_r, ldat_nxt, cdat_r, cdat_nxt;
    logic wait_en_r, wait_en_nxt, req_out_en_r, req_out_en_nxt, release_en_r, release_en_nxt;
    logic [W-1:0] uout_nxt, uoe_nxt, lout_nxt, loe_nxt, cout_nxt, coe_nxt;
    logic [15:0] rdata_nxt;
    logic wait_lvl_nxt, req_in_lvl_nxt;
    logic [W-1:0] ufilt, lfilt, cfilt;
    logic wait_sel, req_out_sel, run;

    assign ufilt = filt_r[W-1:0];
    assign lfilt = filt_r[2*W-1:W];
    assign cfilt = filt_r[3*W-1:2*W];
    assign run = (state_r == BPM_ST_RUN);
    assign wait_sel = exp_r && wait_en_r && !req_out_en_r;
    assign req_out_sel = exp_r && req_out_en_r && !wait_en_r;

    // Straps and registers
    always_comb begin
        state_nxt = state_r;
        wait_nxt = wait_r;
        mode_nxt = mode_r;
        bus16_nxt = bus16_r;
        exp_nxt = exp_r;
        udir_nxt = upper_dir_we ? wr_value : udir_r;
        ldir_nxt = lower_dir_we ? wr_value : ldir_r;
        cdir_nxt = ctrl_dir_we ? wr_value : cdir_r;
        udat_nxt = upper_data_we ? wr_value : udat_r;
        ldat_nxt = lower_data_we ? wr_value : ldat_r;
        cdat_nxt = ctrl_data_we ? wr_value : cdat_r;
        wait_en_nxt = enables_we ? wait_pin_enable_in : wait_en_r;
        req_out_en_nxt = enables_we ? bus_request_out_enable_in : req_out_en_r;
        release_en_nxt = enables_we ? bus_release_enable_in : release_en_r;
        // A change counts once stages two and three agree
        filt_nxt = filt_r;
        for (int i = 0; i < SW; i++) begin
            if (s2_r[i] == s3_r[i]) begin
                filt_nxt[i] = s3_r[i];
            end
        end
        case (state_r)
            BPM_ST_CAPTURE: begin
                // Straps are taken only once the synchroniser has filled
                if (wait_r == BPM_CAPTURE_WAIT) begin
                    state_nxt = BPM_ST_RUN;
                    mode_nxt = filt_nxt[SW-2:SW-4];
                    bus16_nxt = filt_nxt[SW-1];
                    exp_nxt = bpm_is_expanded(filt_nxt[SW-2:SW-4]);
                    cdir_nxt[BPM_CLK_BIT] = bpm_is_expanded(filt_nxt[SW-2:SW-4]) ?
                        BPM_CLKDIR_EXP_RST : BPM_CLKDIR_SC_RST;
                end else begin
                    wait_nxt = 2'(wait_r + 2'h1);
                end
            end
            BPM_ST_RUN: begin
                state_nxt = BPM_ST_RUN;
            end
            default: begin
                state_nxt = BPM_ST_CAPTURE;
            end
        endcase
    end

    // Pin functions
    always_comb begin
        uout_nxt = udat_r;
        uoe_nxt = udir_r;
        lout_nxt = ldat_r;
        loe_nxt = ldir_r;
        cout_nxt = cdat_r;
        coe_nxt = cdir_r;
        if (exp_r) begin
            uout_nxt = bus_wdata[15:8];
            uoe_nxt = {W{bus_drive}};
            if (bus16_r) begin
                lout_nxt = bus_wdata[7:0];
                loe_nxt = {W{bus_drive}};
            end
            cout_nxt[BPM_ADDR_BIT] = address_strobe;
            cout_nxt[BPM_RD_BIT] = read_strobe;
            cout_nxt[BPM_UWR_BIT] = upper_write_strobe;
            cout_nxt[BPM_LOW_WR_BIT] = lower_write_strobe;
            coe_nxt[BPM_ADDR_BIT:BPM_LOW_WR_BIT] = 4'hf;
            if (wait_sel) begin
                coe_nxt[BPM_WAIT_BIT] = 1'b0;
            end else if (req_out_sel) begin
                cout_nxt[BPM_WAIT_BIT] = bus_request_output;
                coe_nxt[BPM_WAIT_BIT] = 1'b1;
            end
            if (release_en_r) begin
                cout_nxt[BPM_GRANT_BIT] = bus_grant_output;
                coe_nxt[BPM_GRANT_BIT] = 1'b1;
                coe_nxt[BPM_REQ_IN_BIT] = 1'b0;
            end
        end
        // Clock pin toggles its own flop, so it runs at half the system clock rate
        cout_nxt[BPM_CLK_BIT] = ~ctrl_pin_out[BPM_CLK_BIT];
        if (!run) begin
            uoe_nxt = '0;
            loe_nxt = '0;
            coe_nxt = '0;
        end
        rdata_nxt = {ufilt, lfilt};
        wait_lvl_nxt = wait_sel ? cfilt[BPM_WAIT_BIT] : BPM_IDLE_LEVEL;
        req_in_lvl_nxt = (exp_r && release_en_r) ? cfilt[BPM_REQ_IN_BIT] : BPM_IDLE_LEVEL;
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
            filt_r <= '0;
            state_r <= BPM_ST_CAPTURE;
            wait_r <= 2'h0;
            mode_r <= 3'h0;
            bus16_r <= 1'b0;
            exp_r <= 1'b0;
            udir_r <= BPM_DIR_RST;
            ldir_r <= BPM_DIR_RST;
            cdir_r <= BPM_DIR_RST;
            udat_r <= BPM_DATA_RST;
            ldat_r <= BPM_DATA_RST;
            cdat_r <= BPM_DATA_RST;
            wait_en_r <= BPM_ENABLE_RST;
            req_out_en_r <= BPM_ENABLE_RST;
            release_en_r <= BPM_ENABLE_RST;
            upper_pin_out <= '0;
            upper_pin_oe <= '0;
            lower_pin_out <= '0;
            lower_pin_oe <= '0;
            ctrl_pin_out <= '0;
            ctrl_pin_oe <= '0;
            bus_rdata <= '0;
            wait_pin_level <= BPM_IDLE_LEVEL;
            bus_request_input <= BPM_IDLE_LEVEL;
            external_interrupt <= '0;
            expanded_mode <= 1'b0;
            upper_pin_state <= '0;
            lower_pin_state <= '0;
            ctrl_pin_state <= '0;
            ctrl_dir <= BPM_DIR_RST;
            pin_enables <= '0;
        end else begin
            s1_r <= {bus16_pin, mode_pins, ctrl_pin_in, lower_pin_in, upper_pin_in};
            s2_r <= s1_r;
            s3_r <= s2_r;
            filt_r <= filt_nxt;
            state_r <= state_nxt;
            wait_r <= wait_nxt;
            mode_r <= mode_nxt;
            bus16_r <= bus16_nxt;
            exp_r <= exp_nxt;
            udir_r <= udir_nxt;
            ldir_r <= ldir_nxt;
            cdir_r <= cdir_nxt;
            udat_r <= udat_nxt;
            ldat_r <= ldat_nxt;
            cdat_r <= cdat_nxt;
            wait_en_r <= wait_en_nxt;
            req_out_en_r <= req_out_en_nxt;
            release_en_r <= release_en_nxt;
            upper_pin_out <= uout_nxt;
            upper_pin_oe <= uoe_nxt;
            lower_pin_out <= lout_nxt;
            lower_pin_oe <= loe_nxt;
            ctrl_pin_out <= cout_nxt;
            ctrl_pin_oe <= coe_nxt;
            bus_rdata <= rdata_nxt;
            wait_pin_level <= wait_lvl_nxt;
            bus_request_input <= req_in_lvl_nxt;
            external_interrupt <= cfilt[3:0];
            expanded_mode <= exp_r;
            upper_pin_state <= ufilt;
            lower_pin_state <= lfilt;
            ctrl_pin_state <= cfilt;
            ctrl_dir <= cdir_r;
            pin_enables <= {release_en_r, req_out_en_r, wait_en_r};
        end
    end

    // Checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);

    a_upper_bus_drive: assert property (run && exp_r |=> upper_pin_oe == {W{$past(bus_drive)}}
        && upper_pin_out == $past(bus_wdata[15:8])) else $error("upper bus byte");
    a_lower_narrow_io: assert property (run && !(exp_r && bus16_r) |=> lower_pin_oe == $past(ldir_r))
        else $error("lower port not gpio");
    a_lower_wide_bus: assert property (run && exp_r && bus16_r |=> lower_pin_out == $past(bus_wdata[7:0]))
        else $error("lower bus byte");
    a_clk_dir_exp: assert property ($rose(run) && exp_r |-> cdir_r[BPM_CLK_BIT])
        else $error("clock dir reset expanded");
    a_clk_dir_single: assert property ($rose(run) && !exp_r |-> !cdir_r[BPM_CLK_BIT])
        else $error("clock dir reset single");
    a_strobe_drive: assert property (run && exp_r |=> ctrl_pin_oe[6:3] == 4'hf
        && ctrl_pin_out[BPM_RD_BIT] == $past(read_strobe)) else $error("strobes");
    a_single_ctrl_io: assert property (run && !exp_r |=> ctrl_pin_oe == $past(cdir_r))
        else $error("single ctrl gpio");
    // Checked only on the first edge after release, so early software writes cannot trip it
    a_enables_reset: assert property (!$past(resetn) |-> !wait_en_r && !req_out_en_r
        && !release_en_r) else $error("enables not reset");
    a_wait_input: assert property (run && wait_sel |=> !ctrl_pin_oe[BPM_WAIT_BIT])
        else $error("wait pin driven");
    a_req_out_drive: assert property (run && req_out_sel |=> ctrl_pin_oe[BPM_WAIT_BIT]
        && ctrl_pin_out[BPM_WAIT_BIT] == $past(bus_request_output))
        else $error("request out");
    a_irq_follow: assert property (##1 external_interrupt == $past(cfilt[3:0]))
        else $error("interrupt lost");
    a_grant_drive: assert property (run && exp_r && release_en_r |=> ctrl_pin_oe[1:0] == 2'h2)
        else $error("grant pins");
    a_pin_state: assert property (s2_r[0] == s3_r[0] |=> ##1 upper_pin_state[0] == $past(s3_r[0], 2))
        else $error("pin state");

    c_expanded_wide: cover property (run && exp_r && bus16_r && bus_drive);
    c_single_chip: cover property (run && !exp_r && ctrl_dir_we);
    c_wait_mode: cover property (run && wait_sel);
    c_bus_release: cover property (run && exp_r && release_en_r);
endmodule : bpm_pin_mux

// ==== verification/bpm_bus_partner.sv ====
// External memory and peripherals sitting on the data and control pins
module bpm_bus_partner (
    // Device side of the pins: upper, lower, control
    dev_out,
    dev_oe,
    // Levels the far side drives when the device lets go
    ext_val,
    data_float,
    // Resolved pin levels
    pin_lvl
);
    timeunit 1ns;
    timeprecision 100ps;
    input wire logic [23:0] dev_out;
    input wire logic [23:0] dev_oe;
    input wire logic [23:0] ext_val;
    input wire logic data_float;
    output logic [23:0] pin_lvl;
    // Device drive wins; with data_float set a released data pin floats up to its pull-up, never to a stale value
    always_comb begin
        for (int i = 0; i < 24; i++) begin
            if (dev_oe[i]) begin
                pin_lvl[i] = dev_out[i];
            end else if (data_float && i >= 8) begin
                pin_lvl[i] = 1'b1;
            end else begin
                pin_lvl[i] = ext_val[i];
            end
        end
    end
endmodule : bpm_bus_partner

// ==== verification/bpm_pin_mux_tb_top.sv ====
// Self-checking bench for the pin function multiplexer
module bpm_pin_mux_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic clock = 1'b0;
    logic resetn = 1'b0;
    logic [2:0] mode = 3'h1;
    logic bus16 = 1'b1;
    logic [7:0] wr_value = 8'h00;
    logic [6:0] we = 7'h00;
    logic [2:0] en = 3'h0;
    logic [15:0] bus_wdata = 16'h0000;
    logic bus_drive = 1'b0;
    logic [3:0] strobes = 4'h0;
    logic req_out = 1'b0;
    logic grant_out = 1'b0;
    logic [23:0] ext_val = 24'h000000;
    logic data_float = 1'b0;
    logic [15:0] bus_rdata;
    logic wait_lvl, req_in, expanded;
    logic [3:0] irq;
    logic [7:0] ups, lps, cps, ctrl_dir;
    logic [2:0] pin_en;
    logic [23:0] pout, poe, pins;
    int err_count = 0;
    int checks_done = 0;
    logic c7;
    always #5 clock = ~clock;
    bpm_pin_mux bpm_pin_mux_i (.clock(clock), .resetn(resetn), .mode_pins(mode),
        .bus16_pin(bus16), .wr_value(wr_value), .upper_dir_we(we[0]), .lower_dir_we(we[1]),
        .ctrl_dir_we(we[2]), .upper_data_we(we[3]), .lower_data_we(we[4]),
        .ctrl_data_we(we[5]), .enables_we(we[6]), .wait_pin_enable_in(en[0]),
        .bus_request_out_enable_in(en[1]), .bus_release_enable_in(en[2]),
        .bus_wdata(bus_wdata), .bus_drive(bus_drive), .address_strobe(strobes[3]),
        .read_strobe(strobes[2]), .upper_write_strobe(strobes[1]),
        .lower_write_strobe(strobes[0]), .bus_request_output(req_out),
        .bus_grant_output(grant_out), .bus_rdata(bus_rdata), .wait_pin_level(wait_lvl),
        .bus_request_input(req_in), .external_interrupt(irq), .expanded_mode(expanded),
        .upper_pin_state(ups), .lower_pin_state(lps), .ctrl_pin_state(cps),
        .ctrl_dir(ctrl_dir), .pin_enables(pin_en), .upper_pin_in(pins[23:16]),
        .upper_pin_out(pout[23:16]), .upper_pin_oe(poe[23:16]), .lower_pin_in(pins[15:8]),
        .lower_pin_out(pout[15:8]), .lower_pin_oe(poe[15:8]), .ctrl_pin_in(pins[7:0]),
        .ctrl_pin_out(pout[7:0]), .ctrl_pin_oe(poe[7:0]));
    bpm_bus_partner bpm_bus_partner_i (.dev_out(pout), .dev_oe(poe), .ext_val(ext_val),
        .data_float(data_float), .pin_lvl(pins));
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : tick
    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    // Mode straps are captured once, so each mode needs its own reset
    task automatic do_reset(input logic [2:0] m, input logic b16);
        @(posedge clock);
        resetn <= 1'b0;
        mode <= m;
        bus16 <= b16;
        tick(16);
        @(posedge clock);
        resetn <= 1'b1;
        tick(7);
    endtask : do_reset
    task automatic wr(input int k, input logic [7:0] v, input logic [2:0] e);
        @(posedge clock);
        we[k] <= 1'b1;
        wr_value <= v;
        en <= e;
        @(posedge clock);
        we[k] <= 1'b0;
        tick(2);
    endtask : wr
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : wrap_up
    initial begin
        repeat (6000) @(posedge clock);
        err_count++;
        wrap_up();
    end
    initial begin
        do_reset(3'h1, 1'b1);
        chk("expanded", 16'h1, expanded);
        chk("clk dir", 16'h1, ctrl_dir[7]);
        chk("enables", 16'h0, pin_en);
        chk("clk oe", 16'h1, poe[7]);
        @(posedge clock);
        bus_drive <= 1'b1;
        bus_wdata <= 16'h1234;
        strobes <= 4'ha;
        tick(3);
        chk("data oe", 16'hffff, poe[23:8]);
        chk("data out", 16'h1234, pout[23:8]);
        chk("strobe oe", 16'hf, poe[6:3]);
        chk("strobes", 16'ha, pout[6:3]);
        @(posedge clock);
        bus_drive <= 1'b0;
        ext_val <= 24'habcd05;
        tick(8);
        chk("rdata", 16'habcd, bus_rdata);
        chk("irq", 16'h5, irq);
        chk("pin state", 16'h55, cps);
        chk("lower state", 16'hcd, lps);
        chk("upper state", 16'hab, ups);
        wr(2, 8'h04, 3'h0);
        wr(5, 8'h04, 3'h0);
        chk("clk in", 16'h0, poe[7]);
        chk("bit2 gpio", 16'h3, {poe[2], pout[2]});
        @(posedge clock);
        ext_val <= 24'h000000;
        wr(6, 8'h00, 3'h1);
        tick(6);
        chk("wait sel", 16'h1, pin_en);
        chk("wait in", 16'h0, {poe[2], wait_lvl});
        wr(6, 8'h00, 3'h6);
        chk("req out", 16'h2, {poe[2], pout[2]});
        tick(6);
        chk("grant", 16'h2, {poe[1], pout[1]});
        chk("request in", 16'h0, req_in);
        $display("test expanded done");
        do_reset(3'h2, 1'b0);
        wr(1, 8'hf0, 3'h0);
        wr(4, 8'h5a, 3'h0);
        @(posedge clock);
        bus_drive <= 1'b1;
        bus_wdata <= 16'h9966;
        tick(3);
        chk("lower oe", 16'hf0, poe[15:8]);
        chk("lower out", 16'h5, pout[15:12]);
        chk("upper oe", 16'hff, poe[23:16]);
        $display("test narrow bus done");
        do_reset(3'h7, 1'b1);
        chk("single", 16'h0, expanded);
        chk("clk dir sc", 16'h0, {ctrl_dir[7], poe[7]});
        chk("upper off", 16'h00, poe[23:16]);
        chk("strobe off", 16'h0, poe[6:3]);
        @(posedge clock);
        data_float <= 1'b1;
        ext_val <= 24'h00000a;
        wr(2, 8'hf8, 3'h0);
        wr(5, 8'h50, 3'h0);
        @(posedge clock);
        strobes <= 4'h5;
        tick(6);
        chk("sc gpio", 16'ha, pout[6:3]);
        chk("sc clk oe", 16'h1, poe[7]);
        c7 = pout[7];
        tick(1);
        chk("clk toggles", {15'h0, ~c7}, pout[7]);
        chk("sc pull", 16'hff, ups);
        chk("sc irq", 16'h2, irq[1:0]);
        $display("test single chip done");
        // Remaining strap codes: expanded flag and clock pin direction after reset
        do_reset(3'h3, 1'b1);
        chk("mode 3", 16'h0, {expanded, ctrl_dir[7]});
        do_reset(3'h4, 1'b1);
        chk("mode 4", 16'h3, {expanded, ctrl_dir[7]});
        do_reset(3'h5, 1'b1);
        chk("mode 5", 16'h3, {expanded, ctrl_dir[7]});
        do_reset(3'h6, 1'b1);
        chk("mode 6", 16'h3, {expanded, ctrl_dir[7]});
        do_reset(3'h0, 1'b1);
        chk("mode 0", 16'h0, {expanded, ctrl_dir[7]});
        $display("test mode decode done");
        wrap_up();
    end
endmodule : bpm_pin_mux_tb_top
